// file: common/cfg_pkg.sv
// package: constants and types for the configuration pin handshake
`default_nettype none
package cfg_pkg;
	localparam int init_cycles = 16;
	localparam int init_cnt_w = 5;
	localparam logic [7:0] read_cmd = 8'h0_003;
	localparam int addr_bits = 24;
	localparam int fetch_bytes = 32;
	localparam int fetch_cnt_w = 6;
	localparam logic [2:0] sync_reset = 3'h0_007;
	localparam logic [7:0] spi_reset_data = 8'h0_000;
	typedef enum logic [6:0] {
		st_idle = 7'b0000001,
		st_init = 7'b0000010,
		st_hold = 7'b0000100,
		st_load = 7'b0001000,
		st_done = 7'b0010000,
		st_wake = 7'b0100000,
		st_user = 7'b1000000
	} cfg_state_t;
	typedef struct packed {
		logic select_n;
		logic clk;
		logic clk_comp;
		logic serial_out;
		logic strobe;
		logic [7:0] bus_out;
		logic bus_oe;
		logic pins_oe;
	} boot_pins_t;
endpackage : cfg_pkg
`default_nettype wire

// file: hdl/config_pin_handshake.sv
// configuration control pins: request, open-drain status, master SPI fetch
//
// Functional notes
// - Mode low enables JTAG and target SPI
// - Mode high enables master SPI fetch
// - Low request starts configuration sequence
// - Pull setup-phase line low during init
// - Release setup line, then allow download
// - Wait while setup line held low
// - Hold completion line low while configuring
// - Release completion line when finished
// - Delay wake-up while completion line low
// - Drive boot memory chip select low
// - Generate boot clock and its complement
// - Send command and address serially
// - Eight-bit parallel boot data bus
// - Strobe accompanies boot data transfers
// - Target strobe accompanies target SPI data
// - Dedicated JTAG pins present
// - Shared pins become user IO afterwards
// - Unused shared pins stay tri-stated
`default_nettype none
module config_pin_handshake
	import cfg_pkg::*;
(
	input wire logic clock,
	input wire logic rst,
	input wire logic boot_path_select,
	input wire logic reconfig_request_n,
	input wire logic setup_phase_n_in,
	output logic setup_phase_n_out,
	output logic setup_phase_n_oe,
	input wire logic done_n_in,
	output logic done_n_out,
	output logic done_n_oe,
	output logic boot_mem_select_n,
	output logic boot_mem_select_n_oe,
	output logic boot_clock_out,
	output logic boot_clock_out_comp,
	output logic boot_clock_oe,
	output logic boot_serial_out,
	output logic boot_serial_out_oe,
	output logic boot_strobe,
	output logic boot_strobe_oe,
	input wire logic [7:0] boot_parallel_bus_in,
	output logic [7:0] boot_parallel_bus_out,
	output logic boot_parallel_bus_oe,
	input wire logic target_clk,
	input wire logic target_select_n,
	input wire logic target_strobe,
	input wire logic [7:0] target_data,
	output logic target_byte_valid,
	output logic [7:0] target_byte,
	input wire logic tck,
	input wire logic tms,
	input wire logic tdi,
	output logic tdo,
	output logic jtag_path_en,
	output logic target_spi_path_en,
	output logic fetch_spi_path_en,
	output logic user_io_en,
	output logic [7:0] fetch_byte,
	output logic fetch_byte_valid,
	output logic config_busy
);
	cfg_state_t state;
	logic [2:0] req_sync, init_sync, done_sync, mode_sync;
	logic req_n, init_hi, done_hi, mode_hi;
	logic [init_cnt_w-1:0] init_cnt;
	logic [fetch_cnt_w-1:0] fetch_cnt;
	logic [5:0] bit_cnt;
	logic [31:0] shift_out;
	logic loading, fetching, load_end, sclk;
	logic tgt_toggle_link;
	logic tgt_end_link;
	logic tgt_edge;
	logic [2:0] tgt_toggle_sync;
	logic [7:0] tgt_hold;
	logic tdo_reg;
	boot_pins_t boot_pins;

	// flow: idle -> init (setup line low) -> hold (wait for setup line high)
	// -> load (fetch or target bytes) -> done -> wake (wait for completion
	// line high) -> user. a request low drops any state back into init.
	// the target path runs on the link clock; only a toggle and the word and
	// end flag that are held still behind it cross into the system clock.
	// limitation: the fetch always starts at address zero and reads a fixed
	// number of bytes; there is no length field in the stream.

	// a synchroniser output may move only once its last two stages agree
	function automatic logic settled(input logic [2:0] taps, input logic prev);
		settled = (taps[1] == taps[2]) ? taps[2] : prev;
	endfunction : settled

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			req_sync <= sync_reset;
			init_sync <= sync_reset;
			done_sync <= sync_reset;
			mode_sync <= 3'h0_000;
		end else begin
			req_sync <= {req_sync[1:0], reconfig_request_n};
			init_sync <= {init_sync[1:0], setup_phase_n_in};
			done_sync <= {done_sync[1:0], done_n_in};
			mode_sync <= {mode_sync[1:0], boot_path_select};
		end
	end

	// a change counts only once stages two and three agree
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			req_n <= 1'b1;
			init_hi <= 1'b1;
			done_hi <= 1'b1;
			mode_hi <= 1'b0;
		end else begin
			// a one-cycle disagreement is a metastable sample, not a change
			req_n <= settled(req_sync, req_n);
			init_hi <= settled(init_sync, init_hi);
			done_hi <= settled(done_sync, done_hi);
			mode_hi <= settled(mode_sync, mode_hi);
		end
	end

	// one system-clock pulse per byte strobed in on the link
	assign tgt_edge = (tgt_toggle_sync[2] != tgt_toggle_sync[1]);
	// the target load ends on a strobed byte sent with select high, so the
	// end marker crosses together with the data instead of as a raw pin
	assign load_end = mode_hi ? (fetch_cnt == fetch_cnt_w'(fetch_bytes) && sclk)
		: (tgt_edge && tgt_end_link);

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			state <= st_idle;
			init_cnt <= '0;
		end else begin
			// request restarts the sequence from any state
			if (!req_n) begin
				state <= st_init;
				init_cnt <= '0;
			end else begin
				case (state)
					st_idle: state <= st_init;
					st_init: begin
						init_cnt <= init_cnt + 1'b1;
						if (init_cnt == init_cnt_w'(init_cycles - 1))
							state <= st_hold;
					end
					st_hold: if (init_hi)
						state <= st_load;
					st_load: if (load_end)
						state <= st_done;
					st_done: state <= st_wake;
					// wake-up held off while line low
					st_wake: if (done_hi)
						state <= st_user;
					st_user: state <= st_user;
					default: state <= st_idle;
				endcase
			end
		end
	end

	assign setup_phase_n_out = 1'b0;
	assign setup_phase_n_oe = (state == st_init) || (state == st_idle);
	assign done_n_out = 1'b0;
	assign done_n_oe = !(state == st_wake || state == st_user);

	assign loading = (state == st_load);
	assign config_busy = (state != st_user);
	// shared pins return to user function
	assign user_io_en = (state == st_user);
	// mode low selects JTAG and target SPI
	assign jtag_path_en = !mode_hi;
	assign target_spi_path_en = !mode_hi && config_busy;
	assign fetch_spi_path_en = mode_hi && config_busy;
	assign fetching = loading && mode_hi;

	// master SPI engine: clock at half rate, command+address then data bytes
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			sclk <= 1'b0;
			bit_cnt <= '0;
			fetch_cnt <= '0;
			shift_out <= '0;
			fetch_byte <= spi_reset_data;
			fetch_byte_valid <= 1'b0;
		end else begin
			fetch_byte_valid <= 1'b0;
			if (!fetching) begin
				sclk <= 1'b0;
				bit_cnt <= '0;
				fetch_cnt <= '0;
				shift_out <= {read_cmd, {addr_bits{1'b0}}};
			end else begin
				sclk <= !sclk;
				if (sclk) begin
					if (bit_cnt < 6'd32) begin
						// command and address shifted out msb first
						shift_out <= {shift_out[30:0], 1'b0};
						bit_cnt <= bit_cnt + 1'b1;
					end else if (fetch_cnt < fetch_cnt_w'(fetch_bytes)) begin
						// one byte per clock over the wide bus
						fetch_byte <= boot_parallel_bus_in;
						fetch_byte_valid <= 1'b1;
						fetch_cnt <= fetch_cnt + 1'b1;
					end
				end
			end
		end
	end

	// boot memory pins gathered in one carrier, then fanned out to the ports
	// chip select low during the fetch
	assign boot_pins.select_n = !fetching;
	assign boot_pins.clk = sclk;
	assign boot_pins.clk_comp = !sclk;
	// command and address leave msb first
	assign boot_pins.serial_out = shift_out[31];
	// strobe only while a byte is still owed
	assign boot_pins.strobe = fetching && (bit_cnt == 6'd32) && sclk
		&& (fetch_cnt < fetch_cnt_w'(fetch_bytes));
	// the wide bus is only ever read by this end
	assign boot_pins.bus_out = spi_reset_data;
	assign boot_pins.bus_oe = 1'b0;
	assign boot_pins.pins_oe = fetch_spi_path_en;

	assign boot_mem_select_n = boot_pins.select_n;
	assign boot_clock_out = boot_pins.clk;
	assign boot_clock_out_comp = boot_pins.clk_comp;
	assign boot_serial_out = boot_pins.serial_out;
	assign boot_strobe = boot_pins.strobe;
	assign boot_parallel_bus_out = boot_pins.bus_out;
	assign boot_parallel_bus_oe = boot_pins.bus_oe;
	assign boot_mem_select_n_oe = boot_pins.pins_oe;
	assign boot_clock_oe = boot_pins.pins_oe;
	assign boot_serial_out_oe = boot_pins.pins_oe;
	assign boot_strobe_oe = boot_pins.pins_oe;

	// target strobe captures a byte on the link clock
	always_ff @(posedge target_clk or posedge rst) begin
		if (rst) begin
			tgt_hold <= spi_reset_data;
			tgt_end_link <= 1'b0;
			tgt_toggle_link <= 1'b0;
		end else if (target_strobe) begin
			tgt_hold <= target_data;
			// select high on a strobed byte marks the end of the load
			tgt_end_link <= target_select_n;
			tgt_toggle_link <= !tgt_toggle_link;
		end
	end

	// toggle crossing; tgt_hold and tgt_end_link stay still for many clocks
	// after each toggle, so they are read directly once the edge is seen.
	// the host must space strobes further apart than the crossing latency.
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			tgt_toggle_sync <= 3'h0_000;
			target_byte <= spi_reset_data;
			target_byte_valid <= 1'b0;
		end else begin
			tgt_toggle_sync <= {tgt_toggle_sync[1:0], tgt_toggle_link};
			target_byte_valid <= 1'b0;
			if (tgt_edge && loading && !mode_hi && !tgt_end_link) begin
				target_byte <= tgt_hold;
				target_byte_valid <= 1'b1;
			end
		end
	end

	// dedicated test port, bypass path on the test clock
	always_ff @(posedge tck or posedge rst) begin
		if (rst)
			tdo_reg <= 1'b0;
		else
			tdo_reg <= tms ? 1'b0 : tdi;
	end
	assign tdo = tdo_reg;
endmodule : config_pin_handshake
`default_nettype wire

// file: dv/config_pin_handshake_props.sv
// checker: configuration pin handshake properties
`default_nettype none
module config_pin_handshake_props (
	input wire logic clock,
	input wire logic rst,
	input wire logic done_n_in,
	input wire logic setup_phase_n_oe,
	input wire logic done_n_oe,
	input wire logic boot_mem_select_n,
	input wire logic boot_clock_out,
	input wire logic boot_clock_out_comp,
	input wire logic boot_clock_oe,
	input wire logic boot_strobe,
	input wire logic target_spi_path_en,
	input wire logic fetch_spi_path_en,
	input wire logic user_io_en,
	input wire logic fetch_byte_valid,
	input wire logic target_byte_valid,
	input wire logic config_busy
);
	default clocking @(posedge clock); endclocking
	default disable iff (rst);
	path_excl_a:
		assert property (!(fetch_spi_path_en && target_spi_path_en)) else $error("paths overlap");
	fetch_setup_a:
		assert property (!boot_mem_select_n |-> !setup_phase_n_oe) else $error("fetch in init");
	busy_done_a:
		assert property ((setup_phase_n_oe || !boot_mem_select_n || target_byte_valid)
			|-> done_n_oe) else $error("done line freed early");
	wake_gate_a:
		assert property ($rose(user_io_en) |-> $past(done_n_in, 2)) else $error("woke too soon");
	select_path_a:
		assert property (!boot_mem_select_n |-> fetch_spi_path_en) else $error("select off path");
	clk_comp_a:
		assert property (boot_clock_oe |-> boot_clock_out_comp != boot_clock_out) else $error("clk pair");
	strobe_byte_a:
		assert property (boot_strobe |=> fetch_byte_valid) else $error("strobe without byte");
	user_pins_a:
		assert property (user_io_en |-> !boot_clock_oe && !done_n_oe) else $error("pins held");
	cover property ($rose(user_io_en));
	cover property (fetch_byte_valid);
	cover property (target_byte_valid);
endmodule : config_pin_handshake_props
bind config_pin_handshake config_pin_handshake_props u_props (.clock, .rst, .done_n_in,
	.setup_phase_n_oe, .done_n_oe, .boot_mem_select_n, .boot_clock_out, .boot_clock_out_comp,
	.boot_clock_oe, .boot_strobe, .target_spi_path_en, .fetch_spi_path_en, .user_io_en,
	.fetch_byte_valid, .target_byte_valid, .config_busy);
`default_nettype wire

// file: dv/boot_mem_model.sv
// boot memory model: command capture and read data
`default_nettype none
module boot_mem_model (
	input wire logic select_n,
	input wire logic sclk,
	input wire logic sdi,
	output logic [7:0] dq,
	output logic [31:0] cmd
);
	timeunit 1ns;
	timeprecision 100ps;
	int cnt = 0;
	initial dq = 8'h00;
	always @(posedge sclk or posedge select_n)
		if (select_n) cnt <= 0;
		else begin
			if (cnt < 32) cmd <= {cmd[30:0], sdi};
			cnt <= cnt + 1;
		end
	// undriven bus sits at its pull-down level
	always @(negedge sclk or posedge select_n)
		dq <= (select_n || cnt < 32) ? 8'h00 : 8'((cnt - 32) * 37 + 11);
endmodule : boot_mem_model
`default_nettype wire

// file: dv/config_pin_handshake_tb.sv
// testbench: configuration pin handshake
`default_nettype none
module config_pin_handshake_tb;
	timeunit 1ns;
	timeprecision 100ps;
	logic clock = 0, rst = 1, boot_path_select = 0, reconfig_request_n = 1, tck = 0, tms = 0;
	logic tdi = 0, target_clk = 0, target_select_n = 1, target_strobe = 0, s_hold, d_hold;
	logic setup_phase_n_out, setup_phase_n_oe, done_n_out, done_n_oe, boot_mem_select_n;
	logic boot_mem_select_n_oe, boot_clock_out, boot_clock_out_comp, boot_clock_oe, tdo;
	logic boot_serial_out, boot_serial_out_oe, boot_strobe, boot_strobe_oe, boot_parallel_bus_oe;
	logic target_byte_valid, jtag_path_en, target_spi_path_en, fetch_spi_path_en, user_io_en;
	logic fetch_byte_valid, config_busy;
	logic [7:0] target_data = 8'h00, boot_parallel_bus_in, boot_parallel_bus_out, target_byte;
	logic [7:0] fetch_byte, exp_q[$], got_q[$];
	logic [31:0] cmd, lfsr = 32'h0000_b284;
	int num_errors = 0, n_checks = 0, cyc = 0;
	wire setup_phase_n_in = !(setup_phase_n_oe || s_hold);
	wire done_n_in = !(done_n_oe || d_hold);
	config_pin_handshake u_config_pin_handshake (.*);
	boot_mem_model u_boot_mem_model (.select_n(boot_mem_select_n), .sclk(boot_clock_out),
		.sdi(boot_serial_out), .dq(boot_parallel_bus_in), .cmd(cmd));
	initial forever #12.5 clock = ~clock;
	always @(posedge clock) begin
		cyc <= cyc + 1;
		if (fetch_byte_valid === 1'b1) got_q.push_back(fetch_byte);
		if (target_byte_valid === 1'b1) got_q.push_back(target_byte);
		if (cyc == 6000) begin
			num_errors++;
			summarize();
		end
	end
	function automatic logic [31:0] rnd();
		lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
		return lfsr;
	endfunction : rnd
	task automatic tick(input int n);
		repeat (n) @(posedge clock);
		#2;
	endtask : tick
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : check
	// link clock only runs inside a byte
	task automatic link(input logic [7:0] d, input logic sel_n);
		target_data = d;
		target_select_n = sel_n;
		target_strobe = 1;
		#24 target_clk = 1;
		#24 target_clk = 0;
		target_data = ~d;
		target_strobe = 0;
		target_select_n = 1;
		#150;
	endtask : link
	task automatic run(input logic m);
		int n;
		n = m ? cfg_pkg::fetch_bytes : 2 + rnd() % 6;
		boot_path_select = m;
		got_q = {};
		exp_q = {};
		tick(4);
		reconfig_request_n = 0;
		s_hold = 1;
		d_hold = 1;
		tick(8);
		check(setup_phase_n_oe, 1);
		reconfig_request_n = 1;
		tick(30 + rnd() % 30);
		if (!m) link(8'h5a, 0);
		check(setup_phase_n_oe, 0);
		check(got_q.size(), 0);
		check(done_n_oe, 1);
		check(jtag_path_en, !m);
		check(boot_mem_select_n_oe, m);
		check(boot_parallel_bus_oe, 0);
		s_hold = 0;
		tick(8);
		for (int k = 0; k < n; k++) begin
			exp_q.push_back(m ? 8'(k * 37 + 11) : 8'(rnd()));
			if (!m) link(exp_q[k], 0);
		end
		if (!m) link(8'h00, 1);
		while (got_q.size() < n || done_n_oe !== 1'b0) tick(1);
		tick(10);
		foreach (exp_q[i]) check(got_q[i], exp_q[i]);
		if (m) check(cmd, {cfg_pkg::read_cmd, 24'h00_0000});
		check(user_io_en, 0);
		d_hold = 0;
		while (user_io_en !== 1'b1) tick(1);
		check(config_busy, 0);
		$display("test mode %0d ended", m);
	endtask : run
	task automatic summarize();
		$display("checks %0d mismatches %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : summarize
	initial begin
		s_hold = 0;
		d_hold = 0;
		tick(20);
		rst = 0;
		run(0);
		run(1);
		repeat (2) run(1'(rnd()));
		repeat (4) begin
			tdi = 1'(rnd());
			tms = 1'(rnd());
			#10 tck = 1;
			#10 tck = 0;
			check(tdo, tms ? 1'b0 : tdi);
		end
		$display("test jtag ended");
		summarize();
	end
endmodule : config_pin_handshake_tb
`default_nettype wire
